// ==== rtl/fixed_priority_interrupt_unit.v ====
/*
 Interrupt unit of an 8-bit core: one non-maskable and four maskable
 sources, fixed priority and vectors, flag pair banking, option register.
 Assumes a core sequencer on pclk that pulses instr_end at each
 instruction boundary and acts on take_q/vector_q, and an APB master.
*/
// Local design decision: the APB slave port.
// Operation
// - NMI preempts all; maskables never nest
// - Maskable order fixed: source one first
// - Fixed vector per source in program space
// - Accepted request loads its vector into PC
// - ORed events keep their own flags
// - Global enable gates maskables, never NMI
// - Enable low: nothing wakes from sleep
// - NMI latched, cleared at its routine start
// - Source one level or falling edge
// - Source two edge, polarity selectable
// - Sources three and four level only
// - Edge latch holds one request only
// - Level requests sampled, never stored
// - Sample at every instruction end
// - Three flag pairs switched automatically
// - Entry: swap flags, push, inhibit, clear, vector
// - Return restores previous flags and PC
// - Early clearing load keeps normal flag pair
// - Option register write-only, reset zero
// - No sleep while enabled request pending
`timescale 1ns/1ps
`default_nettype none
`include "irq_unit_regs.vh"

module fixed_priority_interrupt_unit
(
    // Clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire ce,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Request pins, active low
    input wire nmi_n,
    input wire [7:0] ev_n,
    // Core sequencer
    input wire instr_end,
    input wire return_from_interrupt,
    input wire ldi_opt,
    input wire [1:0] ldi_cycle,
    input wire flags_we,
    input wire carry_in,
    input wire zero_in,
    input wire sleeping,
    output wire carry_flag,
    output wire zero_flag,
    output reg take_q,
    output reg push_pc_q,
    output reg pop_pc_q,
    output reg [11:0] vector_q,
    output wire sleep_ok,
    output reg wake_q
);

    reg [7:0] opt_q;
    reg [1:0] mode_q;
    reg [1:0] saved_mode_q;
    reg [1:0] fset_q;
    reg [1:0] saved_fset_q;
    reg [2:0] carry_q;
    reg [2:0] zero_q;
    reg nmi_lat_q;
    reg edge1_q;
    reg edge2_q;
    reg anom_q;
    reg [7:0] evflag_q;
    reg ack_q;
    reg [8:0] s1_q;
    reg [8:0] s2_q;
    reg [8:0] s3_q;
    reg [8:0] filt_q;
    reg [8:0] filt_prev_q;

    // Option fields, always written as a whole byte
    wire global_irq_enable = opt_q[`OPT_GLOBAL_EN];
    wire src1_level_select = opt_q[`OPT_SRC1_LEVEL];
    wire src2_edge_polarity = opt_q[`OPT_SRC2_POL];

    // Pairs of low-active events OR onto one source line
    function [3:0] src_lines;
        input [7:0] ev;
        begin
            src_lines = {~&ev[7:6], ~&ev[5:4], ~&ev[3:2], ~&ev[1:0]};
        end
    endfunction

    // Source lines are high while any of their events is low
    wire [8:0] fall = filt_prev_q & ~filt_q;
    wire [3:0] ev_act = src_lines(filt_q[7:0]);
    wire [3:0] ev_prev = src_lines(filt_prev_q[7:0]);
    wire src1_fall = ev_act[0] & ~ev_prev[0];
    wire src2_fall = ev_act[1] & ~ev_prev[1];
    wire src2_rise = ~ev_act[1] & ev_prev[1];

    // Raw requests of each maskable source
    // Level sources read the live filtered line; a short pulse is lost
    wire req1 = src1_level_select ? ev_act[0] : edge1_q;
    wire req2 = edge2_q;
    wire req3 = ev_act[2];
    wire req4 = ev_act[3];
    wire any_mask = req1 | req2 | req3 | req4;

    // NMI preempts anything but itself; maskables only from normal mode
    wire nmi_go = nmi_lat_q & (mode_q != `MODE_NMI);
    wire mask_go = global_irq_enable & (mode_q == `MODE_NORMAL) & any_mask;
    wire enabled_pending = nmi_go | mask_go;

    // Fixed priority encoder, source one highest
    function [2:0] pick;
        input r1;
        input r2;
        input r3;
        input r4;
        begin
            if (r1)
                pick = `SRC_ONE;
            else if (r2)
                pick = `SRC_TWO;
            else if (r3)
                pick = `SRC_THREE;
            else if (r4)
                pick = `SRC_FOUR;
            else
                pick = `SRC_NONE;
        end
    endfunction

    function [11:0] vec_of;
        input [2:0] src;
        begin
            case (src)
                `SRC_ONE: vec_of = `VEC_SRC1;
                `SRC_TWO: vec_of = `VEC_SRC2;
                `SRC_THREE: vec_of = `VEC_SRC3;
                `SRC_FOUR: vec_of = `VEC_SRC4;
                default: vec_of = `VEC_SRC0;
            endcase
        end
    endfunction

    wire [2:0] win = pick(req1, req2, req3, req4);
    wire accept = ce & instr_end & enabled_pending;
    wire take_nmi = accept & nmi_go;
    wire take_mask = accept & ~nmi_go;

    // A latch is cleared only when its own source wins the entry
    wire clr_edge1 = take_mask & (win == `SRC_ONE);
    wire clr_edge2 = take_mask & (win == `SRC_TWO);

    // APB decode; writes land at the edge that ends the access
    wire setup_acc = psel & penable;
    wire wr_fire = setup_acc & ack_q & pwrite;
    wire rd_capture = setup_acc & ~ack_q & ~pwrite;
    wire opt_wr = wr_fire & (paddr == `ADDR_OPTIONS);
    wire evt_clr = wr_fire & (paddr == `ADDR_EVENTS);
    wire addr_ok = (paddr == `ADDR_OPTIONS) | (paddr == `ADDR_STATUS)
                   | (paddr == `ADDR_EVENTS);
    // Unmapped offsets answer with an error, never a hang
    assign pready = ack_q;
    assign pslverr = ack_q & ~addr_ok;

    // Current flag pair seen by the core
    assign carry_flag = carry_q[fset_q];
    assign zero_flag = zero_q[fset_q];

    // Sleep is refused while an enabled request waits
    assign sleep_ok = ~enabled_pending;

    // Status mirrors internal state for software polling
    wire [7:0] status = {anom_q, edge2_q, edge1_q, nmi_lat_q, fset_q, mode_q};

    // Pin synchroniser: three stages, a change counts once 2 and 3 agree
    // Filter starts at the idle level so reset gives no false edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= `PIN_IDLE;
            s2_q <= `PIN_IDLE;
            s3_q <= `PIN_IDLE;
            filt_q <= `PIN_IDLE;
            filt_prev_q <= `PIN_IDLE;
        end
        else if (ce)
        begin
            s1_q <= {nmi_n, ev_n};
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
            filt_prev_q <= filt_q;
        end
    end

    // APB handshake: one wait state so read data comes from a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_q <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            ack_q <= setup_acc & ~ack_q;
            if (rd_capture)
            begin
                case (paddr)
                    `ADDR_STATUS: prdata <= {24'h00_0000, status};
                    `ADDR_EVENTS: prdata <= {24'h00_0000, evflag_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Option register, written whole, never read back
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            opt_q <= `OPT_RESET;
        else if (ce & opt_wr)
            opt_q <= pwdata[7:0];
    end

    // Per-event flags; set wins over a software clear
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evflag_q <= 8'h00;
        else if (ce)
        begin
            if (evt_clr)
                evflag_q <= (evflag_q & ~pwdata[7:0]) | fall[7:0];
            else
                evflag_q <= evflag_q | fall[7:0];
        end
    end

    // Request latches: NMI and edge sources
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_lat_q <= 1'b0;
            edge1_q <= 1'b0;
            edge2_q <= 1'b0;
        end
        else if (ce)
        begin
            // A new edge in the clearing cycle survives
            nmi_lat_q <= fall[`PIN_NMI] | (nmi_lat_q & ~take_nmi);
            edge1_q <= (~src1_level_select & src1_fall)
                       | (edge1_q & ~clr_edge1);
            edge2_q <= (src2_edge_polarity ? src2_rise : src2_fall)
                       | (edge2_q & ~clr_edge2);
        end
    end

    // Early clearing load of the option register; the pair switch is
    // skipped only for the entry that follows, later entries switch
    wire anom_arm = ldi_opt & (ldi_cycle < `ANOM_CYCLES) & (mode_q == `MODE_NORMAL)
                    & any_mask & global_irq_enable;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            anom_q <= 1'b0;
        else if (ce)
        begin
            if (accept)
                anom_q <= 1'b0;
            else if (anom_arm)
                anom_q <= 1'b1;
        end
    end

    // Mode and flag pair banking
    // Only an NMI entry saves; a maskable entry always comes from normal
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q <= `MODE_NORMAL;
            saved_mode_q <= `MODE_NORMAL;
            fset_q <= `MODE_NORMAL;
            saved_fset_q <= `MODE_NORMAL;
        end
        else if (ce)
        begin
            if (take_nmi)
            begin
                saved_mode_q <= mode_q;
                saved_fset_q <= fset_q;
                mode_q <= `MODE_NMI;
                fset_q <= `MODE_NMI;
            end
            else if (take_mask)
            begin
                mode_q <= `MODE_IRQ;
                fset_q <= anom_q ? `MODE_NORMAL : `MODE_IRQ;
            end
            else if (return_from_interrupt)
            begin
                if (mode_q == `MODE_NMI)
                begin
                    mode_q <= saved_mode_q;
                    fset_q <= saved_fset_q;
                end
                else
                begin
                    mode_q <= `MODE_NORMAL;
                    fset_q <= `MODE_NORMAL;
                end
            end
        end
    end

    // Flag storage, one pair per mode; only the selected pair is written
    // A routine thus never disturbs the flags of the code it interrupted, except a maskable entry taken with anom_q set
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            carry_q <= 3'h0;
            zero_q <= 3'h0;
        end
        else if (ce & flags_we)
        begin
            carry_q[fset_q] <= carry_in;
            zero_q[fset_q] <= zero_in;
        end
    end

    // Core commands: push and vector on entry, pop on return
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            take_q <= 1'b0;
            push_pc_q <= 1'b0;
            pop_pc_q <= 1'b0;
            vector_q <= `VEC_SRC0;
            wake_q <= 1'b0;
        end
        else if (ce)
        begin
            take_q <= accept;
            push_pc_q <= accept;
            // A stray return in normal mode pops nothing
            pop_pc_q <= return_from_interrupt & ~accept & (mode_q != `MODE_NORMAL);
            if (take_nmi)
                vector_q <= `VEC_SRC0;
            else if (take_mask)
                vector_q <= vec_of(win);
            // Only the global enable arms a wake-up, even for NMI
            wake_q <= sleeping & global_irq_enable & (nmi_lat_q | any_mask);
        end
    end

endmodule

`default_nettype wire

// ==== rtl/irq_unit_regs.vh ====
/*
 Constants of the fixed priority interrupt unit: register map, option
 bit positions, reset values, vectors, mode codes.
 Assumes it is included once per compilation unit by its bare name.
*/
`ifndef IRQ_UNIT_REGS_VH
`define IRQ_UNIT_REGS_VH

// Register byte addresses
`define ADDR_OPTIONS 8'hc8
`define ADDR_STATUS 8'hcc
`define ADDR_EVENTS 8'hd0

// Option register fields and reset value
`define OPT_RESET 8'h00
`define OPT_SRC1_LEVEL 6
`define OPT_SRC2_POL 5
`define OPT_GLOBAL_EN 4

// Source codes of the priority encoder
`define SRC_NONE 3'h0
`define SRC_ONE 3'h1
`define SRC_TWO 3'h2
`define SRC_THREE 3'h3
`define SRC_FOUR 3'h4

// Pin filter: idle level of all lines, position of the NMI line
`define PIN_IDLE 9'h1ff
`define PIN_NMI 8

// Vectors in program space
`define VEC_SRC0 12'hffc
`define VEC_SRC1 12'hff6
`define VEC_SRC2 12'hff4
`define VEC_SRC3 12'hff2
`define VEC_SRC4 12'hff0

// Core modes, also flag pair indices
`define MODE_NORMAL 2'h0
`define MODE_IRQ 2'h1
`define MODE_NMI 2'h2

// Immediate load window in which the flag pair does not switch
`define ANOM_CYCLES 2'h3

// Status register fields
`define ST_MODE 1:0
`define ST_FSET 3:2
`define ST_NMI 4
`define ST_EDGE1 5
`define ST_EDGE2 6
`define ST_ANOM 7

`endif

// ==== testbench/irq_unit_chk.sv ====
/* Port assertions for the interrupt unit.
 Assumes binding onto fixed_priority_interrupt_unit. */
`timescale 1ns/1ps
`default_nettype none
module irq_unit_chk
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core
    input wire logic instr_end,
    input wire logic return_from_interrupt,
    input wire logic take_q,
    input wire logic push_pc_q,
    input wire logic pop_pc_q,
    input wire logic [11:0] vector_q
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_take_push: assert property (take_q == push_pc_q)
        else $error("take and push differ");
    a_take_cause: assert property (take_q |-> $past(instr_end && ce))
        else $error("take without boundary");
    a_take_pulse: assert property (take_q |=> !take_q)
        else $error("take longer than one cycle");
    a_vec_legal: assert property (take_q |-> vector_q inside {12'hffc, 12'hff6, 12'hff4,
        12'hff2, 12'hff0})
        else $error("bad vector");
    a_vec_hold: assert property (!$stable(vector_q) |-> take_q)
        else $error("vector moved without take");
    a_pop_return: assert property (pop_pc_q |-> $past(return_from_interrupt))
        else $error("pop without return");
    a_opt_wo: assert property (pready && !pwrite && paddr == 8'hc8 |-> prdata == 32'h0)
        else $error("option register readable");
    a_err_map: assert property (pslverr |-> pready && !(paddr inside {8'hc8, 8'hcc,
        8'hd0}))
        else $error("error on mapped address");
    a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("wait state count wrong");
    c_nmi: cover property (take_q && vector_q == 12'hffc);
    c_src4: cover property (take_q && vector_q == 12'hff0);
    c_pop: cover property (pop_pc_q);
endmodule
bind fixed_priority_interrupt_unit irq_unit_chk chk (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .instr_end, .return_from_interrupt,
    .take_q, .push_pc_q,
    .pop_pc_q, .vector_q);
`default_nettype wire

// ==== testbench/core_seq.sv ====
/* Core sequencer model: instruction boundary pulses.
 Assumes pclk and presetn of the interrupt unit. */
`timescale 1ns/1ps
`default_nettype none
module core_seq
(
    // Clock, reset
    input wire logic pclk,
    input wire logic presetn,
    // Core state
    input wire logic sleeping,
    output logic instr_end
);
    logic [2:0] cnt_q;
    logic [1:0] len_q;
    // Uneven instruction lengths so sampling never locks to one phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 3'h0;
            len_q <= 2'h0;
            instr_end <= 1'b0;
        end
        else
        begin
            instr_end <= !sleeping && cnt_q == 3'h0;
            if (cnt_q == 3'h0)
            begin
                len_q <= len_q + 2'h1;
                cnt_q <= {1'b0, len_q} + 3'h1;
            end
            else
                cnt_q <= cnt_q - 3'h1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* Directed bench for the interrupt unit.
 Assumes the core model supplies instruction boundaries. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0;
    logic presetn, ce, psel, penable, pwrite, pready, pslverr, nmi_n, ldi_opt;
    logic return_from_interrupt;
    logic flags_we, carry_in, zero_in, sleeping, carry_flag, zero_flag, instr_end;
    logic take_q, push_pc_q, pop_pc_q, sleep_ok, wake_q, err;
    logic [7:0] paddr, ev_n;
    logic [31:0] pwdata, prdata, r;
    logic [1:0] ldi_cycle;
    logic [11:0] vector_q;
    int error_cnt = 0;
    int checked = 0;
    always #50 pclk = ~pclk;
    fixed_priority_interrupt_unit uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nmi_n(nmi_n), .ev_n(ev_n),
        .instr_end(instr_end), .return_from_interrupt(return_from_interrupt),
        .ldi_opt(ldi_opt), .ldi_cycle(ldi_cycle),
        .flags_we(flags_we), .carry_in(carry_in), .zero_in(zero_in), .sleeping(sleeping),
        .carry_flag(carry_flag), .zero_flag(zero_flag), .take_q(take_q),
        .push_pc_q(push_pc_q), .pop_pc_q(pop_pc_q), .vector_q(vector_q),
        .sleep_ok(sleep_ok), .wake_q(wake_q));
    core_seq seq (.pclk(pclk), .presetn(presetn), .sleeping(sleeping), .instr_end(instr_end));
    task automatic close_out();
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n == 50)
            error_cnt++;
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_take(input logic [11:0] exp);
        int n;
        n = 0;
        while (take_q !== 1'b1 && n < 300)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 300)
            error_cnt++;
        chk({20'h0, vector_q}, {20'h0, exp});
        @(posedge pclk);
    endtask
    // Neither a take nor a wake may show in a quiet span
    task automatic quiet(input int c);
        repeat (c)
        begin
            @(posedge pclk);
            chk({31'h0, take_q | wake_q}, 32'h0);
        end
    endtask
    task automatic pulse_return();
        repeat (8) @(posedge pclk);
        return_from_interrupt <= 1'b1;
        @(posedge pclk);
        return_from_interrupt <= 1'b0;
    endtask
    task automatic set_flags(input logic c, input logic z);
        @(posedge pclk);
        flags_we <= 1'b1;
        carry_in <= c;
        zero_in <= z;
        @(posedge pclk);
        flags_we <= 1'b0;
    endtask
    initial
    begin
        #2000000;
        error_cnt++;
        close_out();
    end
    initial
    begin
        {ce, psel, penable, pwrite, return_from_interrupt, ldi_opt} = 6'h20;
        {flags_we, carry_in, zero_in} = 3'h0;
        {presetn, sleeping, nmi_n, ev_n, paddr, pwdata, ldi_cycle} = {3'h1, 8'hff, 42'h0};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'hc8, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        set_flags(1'b1, 1'b0);
        ev_n <= 8'hae;
        repeat (10) @(posedge pclk);
        ev_n[0] <= 1'b1;
        repeat (10) @(posedge pclk);
        ev_n[0] <= 1'b0;
        quiet(20);
        apb(1'b0, 8'hd0, 32'h0);
        chk(r, 32'h51);
        apb(1'b1, 8'hd0, 32'h11);
        apb(1'b0, 8'hd0, 32'h0);
        chk(r, 32'h40);
        apb(1'b1, 8'hc8, 32'h10);
        wait_take(12'hff6);
        chk({30'h0, carry_flag, zero_flag}, 32'h0);
        set_flags(1'b0, 1'b1);
        quiet(30);
        pulse_return();
        wait_take(12'hff2);
        ev_n[4] <= 1'b1;
        pulse_return();
        wait_take(12'hff0);
        ev_n <= 8'hff;
        pulse_return();
        quiet(20);
        chk({30'h0, carry_flag, zero_flag}, 32'h2);
        apb(1'b1, 8'hc8, 32'h30);
        ev_n[2] <= 1'b0;
        quiet(12);
        ev_n[2] <= 1'b1;
        wait_take(12'hff4);
        nmi_n <= 1'b0;
        wait_take(12'hffc);
        nmi_n <= 1'b1;
        quiet(20);
        pulse_return();
        pulse_return();
        apb(1'b1, 8'hc8, 32'h0);
        sleeping <= 1'b1;
        nmi_n <= 1'b0;
        quiet(30);
        nmi_n <= 1'b1;
        sleeping <= 1'b0;
        wait_take(12'hffc);
        pulse_return();
        apb(1'b1, 8'hc8, 32'h10);
        sleeping <= 1'b1;
        ev_n[6] <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({30'h0, wake_q, sleep_ok}, 32'h2);
        ldi_opt <= 1'b1;
        @(posedge pclk);
        ldi_opt <= 1'b0;
        sleeping <= 1'b0;
        wait_take(12'hff0);
        apb(1'b0, 8'hcc, 32'h0);
        chk(r, 32'h1);
        ev_n <= 8'hff;
        pulse_return();
        close_out();
    end
endmodule
`default_nettype wire
